/* File: rtl/bis_pkg.sv */
package bis_pkg;
  localparam int          NUM_CHAN         = 3;
  localparam int          ADDR_W           = 8;
  localparam int          DATA_W           = 8;
  localparam logic [7:0]  ADDR_GATE        = 8'h20;
  localparam logic [7:0]  ADDR_SUMMARY     = 8'h21;
  localparam logic [7:0]  ADDR_SRC_STAT_C0 = 8'h02;
  localparam logic [7:0]  ADDR_SRC_STAT_C1 = 8'h0A;
  localparam logic [7:0]  ADDR_SRC_STAT_C2 = 8'h12;
  localparam logic [7:0]  SUMMARY_RESET    = 8'h00;
  localparam logic [7:0]  GATE_RESET       = 8'h00;
  localparam int          SUMMARY_LSB      = 0;
  localparam int          SUMMARY_MSB      = 2;
endpackage : bis_pkg

/* File: rtl/bis_flag.sv */
`timescale 1ns/10ps
module bis_flag
(
  input  wire logic core_clk,
  input  wire logic rst_n,
  input  wire logic set_req,
  input  wire logic clr_req,
  input  wire logic gate,
  output logic      flag
);
  // R4 R6 latch and gate
  // a closed gate kills the flag; otherwise set wins over a clear in the same cycle
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      flag <= 1'b0;
    else if (!gate)
      flag <= 1'b0;
    else if (set_req)
      flag <= 1'b1;
    else if (clr_req)
      flag <= 1'b0;
  end
endmodule : bis_flag

/* File: rtl/bis_summary.sv */
// Function
// R1 - summary bit 2 is one while channel 2 has a pending interrupt
// R2 - summary bit 1 is one while channel 1 has a pending interrupt
// R3 - summary bit 0 is one while channel 0 has a pending interrupt
// R4 - a set summary bit holds until that channel's source status is read
// R5 - software reads source status at 0x02, 0x0A or 0x12 to find cause
// R6 - a zero block-level gate bit blocks all interrupts of that channel
// R7 - bits 7..3 read zero, writes ignored, all bits reset to zero
`timescale 1ns/10ps
module bis_summary
(
  input  wire logic                       core_clk,
  input  wire logic                       rst_n,
  input  wire logic [bis_pkg::ADDR_W-1:0] reg_addr,
  input  wire logic                       reg_rd,
  input  wire logic                       reg_wr,
  input  wire logic [bis_pkg::DATA_W-1:0] reg_wdata,
  input  wire logic [bis_pkg::NUM_CHAN-1:0] chan_pending,
  input  wire logic [bis_pkg::NUM_CHAN-1:0] chan_gate,
  output logic      [bis_pkg::DATA_W-1:0] reg_rdata,
  output logic                            reg_rd_ack,
  output logic      [bis_pkg::NUM_CHAN-1:0] summary
);
  import bis_pkg::*;

  // source status address of a channel; shared by the clear decode and checks
  function automatic logic [ADDR_W-1:0] src_stat_addr(input int chan);
    logic [ADDR_W-1:0] a;
    a = ADDR_SRC_STAT_C0;
    case (chan)
      1:       a = ADDR_SRC_STAT_C1;
      2:       a = ADDR_SRC_STAT_C2;
      default: a = ADDR_SRC_STAT_C0;
    endcase
    return a;
  endfunction : src_stat_addr

  // one decode for the summary read; the read port and the checks share it
  function automatic logic summary_read(input logic rd, input logic [ADDR_W-1:0] addr);
    return rd && (addr == ADDR_SUMMARY);
  endfunction : summary_read

  // a read at one channel's source status address clears only that channel
  function automatic logic src_read(input logic rd, input logic [ADDR_W-1:0] addr,
                                    input int chan);
    return rd && (addr == src_stat_addr(chan));
  endfunction : src_read

  logic [NUM_CHAN-1:0] src_rd;
  logic                summary_hit;
  logic [DATA_W-1:0]   next_rdata;

  // R7 summary decode
  assign summary_hit = summary_read(reg_rd, reg_addr);

  genvar gi;
  generate
    for (gi = 0; gi < NUM_CHAN; gi++)
    begin : g_chan
      // R5 source read
      assign src_rd[gi] = src_read(reg_rd, reg_addr, gi);
      // R1 R2 R3 R4 R6 per-channel flag
      bis_flag u_flag
      (
        .core_clk (core_clk),
        .rst_n    (rst_n),
        .set_req  (chan_pending[gi]),
        .clr_req  (src_rd[gi]),
        .gate     (chan_gate[gi]),
        .flag     (summary[gi])
      );
    end
  endgenerate

  // R7 read-only view
  // writes are deliberately not decoded: the register has no writable bit
  always_comb
  begin
    next_rdata = SUMMARY_RESET;
    if (summary_hit)
      next_rdata = {{(DATA_W-NUM_CHAN){1'b0}}, summary};
  end

  // R7 registered read data
  // data falls back to zero after its one cycle, so a stale read never shows twice
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      reg_rdata <= SUMMARY_RESET;
    else
      reg_rdata <= next_rdata;
  end

  // R7 read acknowledge
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      reg_rd_ack <= 1'b0;
    else
      reg_rd_ack <= summary_hit;
  end

  // R7 writes are ignored
  logic unused_wr;
  assign unused_wr = reg_wr ^ (^reg_wdata);

  a_chan2_set: assert property (@(posedge core_clk) disable iff (!rst_n) // R1
    chan_pending[2] && chan_gate[2] |=> summary[2])
    else $error("channel 2 pending not flagged");

  a_chan1_set: assert property (@(posedge core_clk) disable iff (!rst_n) // R2
    chan_pending[1] && chan_gate[1] |=> summary[1])
    else $error("channel 1 pending not flagged");

  a_chan0_set: assert property (@(posedge core_clk) disable iff (!rst_n) // R3
    chan_pending[0] && chan_gate[0] |=> summary[0])
    else $error("channel 0 pending not flagged");

  a_flag_holds: assert property (@(posedge core_clk) disable iff (!rst_n) // R4
    summary[1] && chan_gate[1] && !(reg_rd && reg_addr == ADDR_SRC_STAT_C1)
      |=> summary[1])
    else $error("channel 1 flag dropped without source read");

  a_flag_clears: assert property (@(posedge core_clk) disable iff (!rst_n) // R4
    reg_rd && reg_addr == ADDR_SRC_STAT_C2 && !chan_pending[2] |=> !summary[2])
    else $error("channel 2 flag not cleared by source read");

  a_gate_blocks: assert property (@(posedge core_clk) disable iff (!rst_n) // R6
    !chan_gate[0] |=> !summary[0])
    else $error("gated channel 0 still flagged");

  a_read_value: assert property (@(posedge core_clk) disable iff (!rst_n) // R7
    reg_rd && reg_addr == ADDR_SUMMARY
      |=> reg_rd_ack && reg_rdata[7:3] == 5'h0 && reg_rdata[2:0] == $past(summary))
    else $error("summary read data wrong");

  a_write_ignored: assert property (@(posedge core_clk) disable iff (!rst_n) // R7
    reg_wr && !reg_rd && chan_gate == 3'h7
      |=> summary == ($past(summary) | $past(chan_pending)))
    else $error("write changed summary");

  a_write_no_ack: assert property (@(posedge core_clk) disable iff (!rst_n) // R7
    reg_wr && !reg_rd |=> !reg_rd_ack && reg_rdata == 8'h00)
    else $error("write produced read response");

  a_rdata_idle: assert property (@(posedge core_clk) disable iff (!rst_n) // R7
    !summary_read(reg_rd, reg_addr) |=> !reg_rd_ack && reg_rdata == SUMMARY_RESET)
    else $error("read response without summary read");

  a_upper_zero: assert property (@(posedge core_clk) disable iff (!rst_n) // R7
    reg_rdata[7:3] == 5'h00)
    else $error("unused summary bits not zero");

  a_reset_clear: assert property (@(posedge core_clk) // R7
    $rose(rst_n) |-> summary == 3'h0 && !reg_rd_ack && reg_rdata == SUMMARY_RESET)
    else $error("outputs not cleared by reset");

  a_ack_cause: assert property (@(posedge core_clk) disable iff (!rst_n) // R7
    reg_rd_ack |-> $past(summary_read(reg_rd, reg_addr)))
    else $error("ack without summary read");

  a_ack_single: assert property (@(posedge core_clk) disable iff (!rst_n) // R7
    reg_rd_ack && !summary_read(reg_rd, reg_addr) |=> !reg_rd_ack)
    else $error("ack stood longer than one cycle");

  a_src_no_ack: assert property (@(posedge core_clk) disable iff (!rst_n) // R7
    src_read(reg_rd, reg_addr, 1) |=> !reg_rd_ack)
    else $error("source status read acknowledged here");

  a_read_keeps: assert property (@(posedge core_clk) disable iff (!rst_n) // R4
    summary_read(reg_rd, reg_addr) && chan_gate == 3'h7
      |=> summary == ($past(summary) | $past(chan_pending)))
    else $error("summary read changed flags");

  a_chan2_hold: assert property (@(posedge core_clk) disable iff (!rst_n) // R4
    summary[2] && chan_gate[2] && !src_read(reg_rd, reg_addr, 2)
      |=> summary[2])
    else $error("channel 2 flag dropped without source read");

  a_chan0_hold: assert property (@(posedge core_clk) disable iff (!rst_n) // R4
    summary[0] && chan_gate[0] && !src_read(reg_rd, reg_addr, 0)
      |=> summary[0])
    else $error("channel 0 flag dropped without source read");

  a_chan0_clears: assert property (@(posedge core_clk) disable iff (!rst_n) // R4
    src_read(reg_rd, reg_addr, 0) && !chan_pending[0] |=> !summary[0])
    else $error("channel 0 flag not cleared by source read");

  a_chan1_clears: assert property (@(posedge core_clk) disable iff (!rst_n) // R4
    src_read(reg_rd, reg_addr, 1) && !chan_pending[1] |=> !summary[1])
    else $error("channel 1 flag not cleared by source read");

  a_gate1_blocks: assert property (@(posedge core_clk) disable iff (!rst_n) // R6
    !chan_gate[1] |=> !summary[1])
    else $error("gated channel 1 still flagged");

  a_gate2_blocks: assert property (@(posedge core_clk) disable iff (!rst_n) // R6
    !chan_gate[2] |=> !summary[2])
    else $error("gated channel 2 still flagged");

  a_chan2_quiet: assert property (@(posedge core_clk) disable iff (!rst_n) // R1
    !summary[2] && !(chan_pending[2] && chan_gate[2]) |=> !summary[2])
    else $error("channel 2 flagged with nothing pending");

  a_chan1_quiet: assert property (@(posedge core_clk) disable iff (!rst_n) // R2
    !summary[1] && !(chan_pending[1] && chan_gate[1]) |=> !summary[1])
    else $error("channel 1 flagged with nothing pending");

  a_chan0_quiet: assert property (@(posedge core_clk) disable iff (!rst_n) // R3
    !summary[0] && !(chan_pending[0] && chan_gate[0]) |=> !summary[0])
    else $error("channel 0 flagged with nothing pending");

  a_chan2_set_wins: assert property (@(posedge core_clk) disable iff (!rst_n) // R1
    src_read(reg_rd, reg_addr, 2) && chan_pending[2] && chan_gate[2] |=> summary[2])
    else $error("channel 2 clear beat a new event");

  a_chan1_set_wins: assert property (@(posedge core_clk) disable iff (!rst_n) // R2
    src_read(reg_rd, reg_addr, 1) && chan_pending[1] && chan_gate[1] |=> summary[1])
    else $error("channel 1 clear beat a new event");

  a_chan0_set_wins: assert property (@(posedge core_clk) disable iff (!rst_n) // R3
    src_read(reg_rd, reg_addr, 0) && chan_pending[0] && chan_gate[0] |=> summary[0])
    else $error("channel 0 clear beat a new event");
endmodule : bis_summary

/* File: bench/block_interrupt_summary_test.sv */
`timescale 1ns/10ps
module block_interrupt_summary_test;
  import bis_pkg::*;
  logic       core_clk;
  logic       rst_n;
  logic [7:0] reg_addr;
  logic       reg_rd;
  logic       reg_wr;
  logic [7:0] reg_wdata;
  logic [2:0] chan_pending;
  logic [2:0] chan_gate;
  logic [7:0] reg_rdata;
  logic       reg_rd_ack;
  logic [2:0] summary;
  int         mismatches;
  int         n_checks;
  int         cycles;
  bis_summary dut (.core_clk(core_clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_rd(reg_rd),
    .reg_wr(reg_wr), .reg_wdata(reg_wdata), .chan_pending(chan_pending),
    .chan_gate(chan_gate), .reg_rdata(reg_rdata), .reg_rd_ack(reg_rd_ack), .summary(summary));
  initial
  begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      mismatches++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  // ack only for the summary address; rdata is sampled in its one valid cycle
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge core_clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1;
    chk({7'h00, reg_rd_ack}, {7'h00, a == ADDR_SUMMARY});
    chk(reg_rdata, exp);
  endtask : rd
  task automatic t_flag;
    logic [7:0] src [3] = '{ADDR_SRC_STAT_C0, ADDR_SRC_STAT_C1, ADDR_SRC_STAT_C2};
    for (int i = 0; i < 3; i++)
    begin
      @(posedge core_clk);
      chan_gate    <= 3'h7;
      chan_pending <= 3'(1 << i);
      @(posedge core_clk);
      chan_pending <= 3'h0;
      repeat (3) @(posedge core_clk);
      #1 chk({5'h00, summary}, 8'(1 << i));
      rd(ADDR_SUMMARY, 8'(1 << i));
      rd(src[i], 8'h00);
      chk({5'h00, summary}, 8'h00);
    end
  endtask : t_flag
  task automatic t_gate;
    @(posedge core_clk);
    chan_gate    <= 3'h0;
    chan_pending <= 3'h7;
    repeat (3) @(posedge core_clk);
    chan_gate <= 3'h7;
    #1 chk({5'h00, summary}, 8'h00);
    @(posedge core_clk);
    chan_pending <= 3'h0;
    reg_wr       <= 1'b1;
    reg_addr     <= ADDR_SUMMARY;
    reg_wdata    <= 8'h00;
    @(posedge core_clk);
    reg_wdata <= 8'hff;
    @(posedge core_clk);
    reg_wr <= 1'b0;
    #1 chk({5'h00, summary}, 8'h07);
    rd(ADDR_SUMMARY, 8'h07);
    @(posedge core_clk);
    chan_gate <= 3'h0;
    @(posedge core_clk);
    #1 chk({5'h00, summary}, 8'h00);
  endtask : t_gate
  // a new event in the cycle of its clear keeps the flag; other channels stay untouched
  task automatic t_order;
    @(posedge core_clk);
    chan_gate    <= 3'h7;
    chan_pending <= 3'h7;
    rd(ADDR_SRC_STAT_C0, 8'h00);
    rd(ADDR_SRC_STAT_C1, 8'h00);
    rd(ADDR_SRC_STAT_C2, 8'h00);
    chk({5'h00, summary}, 8'h07);
    @(posedge core_clk);
    chan_pending <= 3'h0;
    rd(ADDR_SRC_STAT_C1, 8'h00);
    chk({5'h00, summary}, 8'h05);
    rd(ADDR_SUMMARY, 8'h05);
  endtask : t_order
  task automatic t_reset;
    @(posedge core_clk);
    rst_n <= 1'b0;
    @(posedge core_clk);
    #1 chk({5'h00, summary}, 8'h00);
    chk(reg_rdata, SUMMARY_RESET);
    @(posedge core_clk);
    rst_n <= 1'b1;
    rd(ADDR_SUMMARY, SUMMARY_RESET);
  endtask : t_reset
  task automatic conclude;
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : conclude
  // whole run is well under 200 cycles; 2000 leaves margin for a stuck wait
  always @(posedge core_clk)
  begin
    cycles++;
    if (cycles == 2000)
    begin
      mismatches++;
      conclude;
    end
  end
  initial
  begin
    {rst_n, reg_rd, reg_wr, reg_addr, reg_wdata, chan_pending, chan_gate} = '0;
    repeat (20) @(posedge core_clk);
    rst_n <= 1'b1;
    rd(ADDR_SUMMARY, SUMMARY_RESET);
    t_flag;
    t_gate;
    t_order;
    t_reset;
    conclude;
  end
endmodule : block_interrupt_summary_test
